/* sjt_pkg.sv */
// Shared constants and types of the memory scan test port and its controller.
package sjt_pkg;
    // ************************************************************
    // Instruction encodings
    // ************************************************************
    localparam logic [2:0] SJT_IR_EXTEST = 3'h0;
    localparam logic [2:0] SJT_IR_IDCODE = 3'h1;
    localparam logic [2:0] SJT_IR_SAMPLEZ = 3'h2;
    localparam logic [2:0] SJT_IR_RSV3 = 3'h3;
    localparam logic [2:0] SJT_IR_SAMPLE = 3'h4;
    localparam logic [2:0] SJT_IR_RSV5 = 3'h5;
    localparam logic [2:0] SJT_IR_RSV6 = 3'h6;
    localparam logic [2:0] SJT_IR_BYPASS = 3'h7;
    localparam logic [1:0] SJT_IR_CAPTURE = 2'h1;

    // ************************************************************
    // Register sizes and reset values
    // ************************************************************
    localparam int SJT_IR_W = 3;
    localparam int SJT_ID_W = 32;
    localparam int SJT_BSR_W = 71;
    // Identification value is arbitrary; bit 0 marks the register as present.
    localparam logic [31:0] SJT_ID_VALUE = 32'h0a5c_3e71;
    localparam logic [2:0] SJT_IR_RESET = 3'h1;
    localparam int SJT_RESET_TMS_EDGES = 5;

    // ************************************************************
    // Timing: controller's test clock at most 20 MHz (50 ns period)
    // ************************************************************
    localparam int SJT_CLK_NS = 4;
    localparam int SJT_TCK_MIN_NS = 50;
    localparam int SJT_TCK_HALF_CYC = (SJT_TCK_MIN_NS / 2 + SJT_CLK_NS - 1) / SJT_CLK_NS;

    typedef enum logic [3:0] {
        SJT_TLR, SJT_RTI, SJT_SEL_DR, SJT_CAP_DR, SJT_SH_DR, SJT_EX1_DR, SJT_PA_DR,
        SJT_EX2_DR, SJT_UPD_DR, SJT_SEL_IR, SJT_CAP_IR, SJT_SH_IR, SJT_EX1_IR,
        SJT_PA_IR, SJT_EX2_IR, SJT_UPD_IR
    } sjt_state_e;

    function automatic sjt_state_e sjt_next(input sjt_state_e s, input logic tms);
        unique case (s)
            SJT_TLR: sjt_next = tms ? SJT_TLR : SJT_RTI;
            SJT_RTI: sjt_next = tms ? SJT_SEL_DR : SJT_RTI;
            SJT_SEL_DR: sjt_next = tms ? SJT_SEL_IR : SJT_CAP_DR;
            SJT_CAP_DR: sjt_next = tms ? SJT_EX1_DR : SJT_SH_DR;
            SJT_SH_DR: sjt_next = tms ? SJT_EX1_DR : SJT_SH_DR;
            SJT_EX1_DR: sjt_next = tms ? SJT_UPD_DR : SJT_PA_DR;
            SJT_PA_DR: sjt_next = tms ? SJT_EX2_DR : SJT_PA_DR;
            SJT_EX2_DR: sjt_next = tms ? SJT_UPD_DR : SJT_SH_DR;
            SJT_UPD_DR: sjt_next = tms ? SJT_SEL_DR : SJT_RTI;
            SJT_SEL_IR: sjt_next = tms ? SJT_TLR : SJT_CAP_IR;
            SJT_CAP_IR: sjt_next = tms ? SJT_EX1_IR : SJT_SH_IR;
            SJT_SH_IR: sjt_next = tms ? SJT_EX1_IR : SJT_SH_IR;
            SJT_EX1_IR: sjt_next = tms ? SJT_UPD_IR : SJT_PA_IR;
            SJT_PA_IR: sjt_next = tms ? SJT_EX2_IR : SJT_PA_IR;
            SJT_EX2_IR: sjt_next = tms ? SJT_UPD_IR : SJT_SH_IR;
            SJT_UPD_IR: sjt_next = tms ? SJT_SEL_DR : SJT_RTI;
        endcase
    endfunction : sjt_next
endpackage : sjt_pkg

/* sjt_if.sv */
// Scan port wires between the memory test port and the external controller.
`timescale 1ns/10ps
`default_nettype none
interface sjt_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
    modport ctl (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface : sjt_if
`default_nettype wire

/* sjt_tap.sv */
// Memory scan test port: state machine, instruction decode and data registers.
`timescale 1ns/10ps
`default_nettype none
module sjt_tap (
    input wire logic i_clk,
    input wire logic i_reset,
    sjt_if.dev port,
    input wire logic [sjt_pkg::SJT_BSR_W-1:0] i_ring,
    output logic o_outputs_hiz,
    output logic [2:0] o_instr
);
    import sjt_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [1:0] tck_s;
        logic tck_d;
        logic [1:0] tms_s;
        logic [1:0] tdi_s;
        sjt_state_e st;
        logic [SJT_IR_W-1:0] ir_sh;
        logic [SJT_IR_W-1:0] ir;
        logic [SJT_ID_W-1:0] id_sh;
        logic [SJT_BSR_W-1:0] bsr;
        logic byp;
        logic tdo;
        logic tdo_oe;
        logic hiz;
    } sjt_tap_s;

    sjt_tap_s s_r;
    sjt_tap_s s_nxt;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic tck_rise;
        logic tck_fall;
        logic tms;
        logic tdi;
        logic ser;
        tck_rise = 1'b0;
        tck_fall = 1'b0;
        tms = 1'b0;
        tdi = 1'b0;
        ser = 1'b0;
        s_nxt = s_r;
        s_nxt.tck_s = {s_r.tck_s[0], port.tck};
        s_nxt.tms_s = {s_r.tms_s[0], port.tms};
        s_nxt.tdi_s = {s_r.tdi_s[0], port.tdi};
        s_nxt.tck_d = s_r.tck_s[1];
        tck_rise = s_r.tck_s[1] & ~s_r.tck_d;
        tck_fall = ~s_r.tck_s[1] & s_r.tck_d;
        tms = s_r.tms_s[1];
        tdi = s_r.tdi_s[1];
        if (tck_rise) begin
            s_nxt.st = sjt_next(s_r.st, tms);
            unique case (s_r.st)
                SJT_TLR: s_nxt.ir = SJT_IR_RESET;
                SJT_CAP_IR: s_nxt.ir_sh = {1'b0, SJT_IR_CAPTURE};
                SJT_SH_IR: s_nxt.ir_sh = {tdi, s_r.ir_sh[SJT_IR_W-1:1]};
                SJT_UPD_IR: s_nxt.ir = s_r.ir_sh;
                SJT_CAP_DR: begin
                    // The ring is only ever captured, never driven back out.
                    unique case (s_r.ir)
                        SJT_IR_IDCODE: s_nxt.id_sh = SJT_ID_VALUE;
                        SJT_IR_EXTEST, SJT_IR_SAMPLEZ, SJT_IR_SAMPLE: s_nxt.bsr = i_ring;
                        SJT_IR_BYPASS: s_nxt.byp = 1'b0;
                        SJT_IR_RSV3, SJT_IR_RSV5, SJT_IR_RSV6: s_nxt.byp = 1'b0;
                    endcase
                end
                SJT_SH_DR: begin
                    unique case (s_r.ir)
                        SJT_IR_IDCODE: s_nxt.id_sh = {tdi, s_r.id_sh[SJT_ID_W-1:1]};
                        SJT_IR_EXTEST, SJT_IR_SAMPLEZ, SJT_IR_SAMPLE:
                            s_nxt.bsr = {tdi, s_r.bsr[SJT_BSR_W-1:1]};
                        SJT_IR_BYPASS, SJT_IR_RSV3, SJT_IR_RSV5, SJT_IR_RSV6:
                            s_nxt.byp = tdi;
                    endcase
                end
                default: s_nxt.ir = s_r.ir;
            endcase
        end
        if (s_r.st == SJT_SH_IR) begin
            ser = s_r.ir_sh[0];
        end else begin
            unique case (s_r.ir)
                SJT_IR_IDCODE: ser = s_r.id_sh[0];
                SJT_IR_EXTEST, SJT_IR_SAMPLEZ, SJT_IR_SAMPLE: ser = s_r.bsr[0];
                SJT_IR_BYPASS, SJT_IR_RSV3, SJT_IR_RSV5, SJT_IR_RSV6: ser = s_r.byp;
            endcase
        end
        if (tck_fall) begin
            s_nxt.tdo = ser;
            s_nxt.tdo_oe = (s_r.st == SJT_SH_IR) || (s_r.st == SJT_SH_DR);
        end
        // Reserved codes fall back to the bypass path so the chain stays intact.
        s_nxt.hiz = (s_r.ir == SJT_IR_EXTEST) || (s_r.ir == SJT_IR_SAMPLEZ);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_r <= '{tck_s: 2'h0, tck_d: 1'b0, tms_s: 2'h3, tdi_s: 2'h3, st: SJT_TLR,
                     ir_sh: 3'h0, ir: SJT_IR_RESET, id_sh: 32'h0, bsr: '0, byp: 1'b0,
                     tdo: 1'b0, tdo_oe: 1'b0, hiz: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign port.tdo = s_r.tdo;
    assign port.tdo_oe = s_r.tdo_oe;
    assign o_outputs_hiz = s_r.hiz;
    assign o_instr = s_r.ir;
endmodule : sjt_tap
`default_nettype wire

/* sjt_ctl.sv */
// External scan controller: makes the test clock and runs one scan of n bits.
`timescale 1ns/10ps
`default_nettype none
module sjt_ctl (
    input wire logic i_clk,
    input wire logic i_reset,
    sjt_if.ctl port,
    input wire logic i_start,
    input wire logic i_ir_scan,
    input wire logic i_reset_port,
    input wire logic [6:0] i_len,
    input wire logic [sjt_pkg::SJT_BSR_W-1:0] i_data,
    output logic o_busy,
    output logic o_done,
    output logic [sjt_pkg::SJT_BSR_W-1:0] o_data
);
    import sjt_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {CT_IDLE, CT_RUN} sjt_ct_e;
    typedef struct packed {
        sjt_ct_e ph;
        logic [7:0] div;
        logic tck;
        logic tms;
        logic tdi;
        logic [1:0] tdo_s;
        sjt_state_e st;
        logic [6:0] left;
        logic ir_scan;
        logic rst_req;
        logic [2:0] tms_cnt;
        logic [SJT_BSR_W-1:0] sh;
        logic [SJT_BSR_W-1:0] out;
        logic done;
    } sjt_ctl_s;

    sjt_ctl_s s_r;
    sjt_ctl_s s_nxt;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic next_tms;
        next_tms = 1'b0;
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.tdo_s = {s_r.tdo_s[0], port.tdo};
        unique case (s_r.ph)
            CT_IDLE: begin
                // The clock rests at the level of the final edge, so no runt pulse follows a scan.
                if (i_start) begin
                    s_nxt.ph = CT_RUN;
                    s_nxt.ir_scan = i_ir_scan;
                    s_nxt.rst_req = i_reset_port;
                    s_nxt.tms_cnt = 3'h0;
                    s_nxt.left = i_len;
                    s_nxt.sh = i_data;
                    s_nxt.div = 8'h0;
                end
            end
            CT_RUN: begin
                // Half period held at least 25 ns keeps the clock at 20 MHz or below.
                if (s_r.div == 8'(SJT_TCK_HALF_CYC - 1)) begin
                    s_nxt.div = 8'h0;
                    s_nxt.tck = ~s_r.tck;
                    if (s_r.tck) begin
                        // Falling edge: set TMS and TDI for the next rise.
                        if (s_r.rst_req) begin
                            next_tms = 1'b1;
                        end else begin
                            unique case (s_r.st)
                                SJT_TLR, SJT_UPD_DR, SJT_UPD_IR: next_tms = 1'b0;
                                SJT_RTI: next_tms = 1'b1;
                                SJT_SEL_DR: next_tms = s_r.ir_scan;
                                SJT_SH_DR, SJT_SH_IR: next_tms = (s_r.left == 7'h1);
                                SJT_EX1_DR, SJT_EX1_IR: next_tms = 1'b1;
                                default: next_tms = 1'b0;
                            endcase
                            if (s_r.st == SJT_SEL_DR && !s_r.ir_scan) next_tms = 1'b0;
                        end
                        s_nxt.tms = next_tms;
                        s_nxt.tdi = s_r.sh[0];
                    end else begin
                        // Rising edge: follow the port's state machine.
                        s_nxt.st = sjt_next(s_r.st, s_r.tms);
                        if (s_r.st == SJT_SH_DR || s_r.st == SJT_SH_IR) begin
                            s_nxt.sh = {s_r.tdo_s[1], s_r.sh[SJT_BSR_W-1:1]};
                            s_nxt.left = s_r.left - 7'h1;
                        end
                        if (s_r.rst_req) begin
                            s_nxt.tms_cnt = s_r.tms_cnt + 3'h1;
                            if (s_r.tms_cnt == 3'(SJT_RESET_TMS_EDGES - 1)) begin
                                s_nxt.ph = CT_IDLE;
                                s_nxt.done = 1'b1;
                                s_nxt.st = SJT_TLR;
                            end
                        end else if (s_r.st == SJT_UPD_DR || s_r.st == SJT_UPD_IR) begin
                            s_nxt.ph = CT_IDLE;
                            s_nxt.done = 1'b1;
                            // Captured bits sit in the top i_len bits of the shift register.
                            s_nxt.out = s_r.sh;
                        end
                    end
                end else begin
                    s_nxt.div = s_r.div + 8'h1;
                end
            end
            default: s_nxt.ph = CT_IDLE;
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_r <= '{ph: CT_IDLE, div: 8'h0, tck: 1'b0, tms: 1'b1, tdi: 1'b1, tdo_s: 2'h0,
                     st: SJT_TLR, left: 7'h0, ir_scan: 1'b0, rst_req: 1'b0, tms_cnt: 3'h0,
                     sh: '0, out: '0, done: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign port.tck = s_r.tck;
    assign port.tms = s_r.tms;
    assign port.tdi = s_r.tdi;
    assign o_busy = (s_r.ph == CT_RUN);
    assign o_done = s_r.done;
    assign o_data = s_r.out;
endmodule : sjt_ctl
`default_nettype wire

/* sjt_checker.sv */
// Assertions on the scan port wires and the port's decoded outputs.
`timescale 1ns/10ps
`default_nettype none
module sjt_checker (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [2:0] o_instr,
    input wire logic o_outputs_hiz
);
    logic tck_d_r;
    logic [2:0] hi_cnt_r;
    // Counts consecutive rising test-clock edges with mode select high, saturating at five.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tck_d_r <= 1'b0;
            hi_cnt_r <= 3'h0;
        end else begin
            tck_d_r <= tck;
            if (tck && !tck_d_r) begin
                hi_cnt_r <= !tms ? 3'h0 : (hi_cnt_r == 3'h5 ? 3'h5 : hi_cnt_r + 3'h1);
            end
        end
    end
    // ********
    // Properties
    // ********
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    chk_tck_high_time: assert property ($rose(tck) |=> tck [*6])
        else $error("test clock high phase too short");
    chk_tck_low_time: assert property ($fell(tck) |=> !tck [*6])
        else $error("test clock low phase too short");
    chk_tms_setup: assert property ($changed(tms) |-> !tck)
        else $error("mode select moved while test clock high");
    chk_tdi_setup: assert property ($changed(tdi) |-> !tck)
        else $error("data in moved while test clock high");
    chk_tdo_on_fall: assert property ($changed(tdo) |-> !tck)
        else $error("data out moved while test clock high");
    chk_oe_on_fall: assert property ($changed(tdo_oe) |-> !tck)
        else $error("data out enable moved while test clock high");
    chk_instr_update: assert property ($changed(o_instr) |-> tck)
        else $error("instruction changed away from a rising test clock");
    chk_hiz_decode: assert property ($stable(o_instr) [*3]
        |-> o_outputs_hiz == (o_instr == 3'h0 || o_instr == 3'h2))
        else $error("output float does not match instruction");
    chk_port_reset: assert property (hi_cnt_r == 3'h5 |-> ##[0:8] o_instr == 3'h1)
        else $error("five high mode edges did not restore identification");
    cover property (o_outputs_hiz);
    cover property (hi_cnt_r == 3'h5);
    cover property ($rose(tdo_oe));
endmodule : sjt_checker
`default_nettype wire

/* tb.sv */
// Self-checking bench joining the scan port to its controller.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import sjt_pkg::*;
    localparam logic [70:0] RING = {7'h5a, 64'h0123_4567_89ab_cdef};
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic start = 1'b0;
    logic ir_scan = 1'b0;
    logic reset_port = 1'b0;
    logic [6:0] len = 7'h0;
    logic [70:0] data = 71'h0;
    logic [70:0] ring = RING;
    logic [70:0] rdata;
    logic busy;
    logic done;
    logic hiz;
    logic [2:0] instr;
    int num_errors = 0;
    int check_count = 0;
    sjt_if port ();
    sjt_tap i_sjt_tap (.i_clk(i_clk), .i_reset(i_reset), .port(port), .i_ring(ring),
        .o_outputs_hiz(hiz), .o_instr(instr));
    sjt_ctl i_sjt_ctl (.i_clk(i_clk), .i_reset(i_reset), .port(port), .i_start(start),
        .i_ir_scan(ir_scan), .i_reset_port(reset_port), .i_len(len), .i_data(data),
        .o_busy(busy), .o_done(done), .o_data(rdata));
    sjt_checker i_sjt_checker (.i_clk(i_clk), .i_reset(i_reset), .tck(port.tck),
        .tms(port.tms), .tdi(port.tdi), .tdo(port.tdo), .tdo_oe(port.tdo_oe),
        .o_instr(instr), .o_outputs_hiz(hiz));
    initial begin
        forever #2 i_clk = ~i_clk;
    end
    // ********
    // Shared tasks
    // ********
    task automatic check(input logic [70:0] seen, input logic [70:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // Runs one scan and waits for the port to settle after the final edge.
    task automatic scan(input logic ir, input logic rp, input logic [6:0] n,
        input logic [70:0] d);
        int k;
        @(posedge i_clk);
        #1;
        ir_scan = ir;
        reset_port = rp;
        len = n;
        data = d;
        start = 1'b1;
        @(posedge i_clk);
        #1;
        start = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 4000) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        if (k >= 4000) begin
            num_errors++;
            test_done();
        end
        repeat (8) @(posedge i_clk);
        #1;
    endtask : scan
    // ********
    // Scenarios
    // ********
    task automatic t_power_up();
        check(71'(instr), 71'h1);
        check(71'(hiz), 71'h0);
        check(71'(port.tdo_oe), 71'h0);
        $display("test power_up done");
    endtask : t_power_up
    task automatic t_ir_codes();
        // Only the five implemented codes are ever loaded.
        logic [2:0] codes [5] = '{SJT_IR_EXTEST, SJT_IR_IDCODE, SJT_IR_SAMPLEZ, SJT_IR_SAMPLE,
            SJT_IR_BYPASS};
        foreach (codes[i]) begin
            scan(1'b1, 1'b0, 7'h3, 71'(codes[i]));
            check(71'(rdata[70:68]), 71'(SJT_IR_CAPTURE));
            check(71'(instr), 71'(codes[i]));
            check(71'(hiz), 71'(codes[i] == SJT_IR_EXTEST || codes[i] == SJT_IR_SAMPLEZ));
        end
        $display("test ir_codes done");
    endtask : t_ir_codes
    task automatic t_idcode();
        scan(1'b0, 1'b1, 7'h0, 71'h0);
        check(71'(instr), 71'(SJT_IR_IDCODE));
        scan(1'b0, 1'b0, 7'h20, 71'h0);
        check(71'(rdata[70:39]), 71'(SJT_ID_VALUE));
        $display("test idcode done");
    endtask : t_idcode
    task automatic t_bypass();
        logic [2:0] codes [2] = '{SJT_IR_BYPASS, SJT_IR_BYPASS};
        foreach (codes[i]) begin
            scan(1'b1, 1'b0, 7'h3, 71'(codes[i]));
            scan(1'b0, 1'b0, 7'h2, 71'h1);
            check(71'(rdata[70:69]), 71'h2);
        end
        $display("test bypass done");
    endtask : t_bypass
    task automatic t_ring();
        logic [2:0] codes [3] = '{SJT_IR_SAMPLE, SJT_IR_EXTEST, SJT_IR_SAMPLEZ};
        foreach (codes[i]) begin
            scan(1'b1, 1'b0, 7'h3, 71'(codes[i]));
            check(71'(hiz), 71'(i != 0));
            scan(1'b0, 1'b0, 7'h47, ~RING);
            check(rdata, RING);
            scan(1'b0, 1'b0, 7'h47, 71'h0);
            check(rdata, RING);
        end
        $display("test ring done");
    endtask : t_ring
    initial begin
        repeat (16) @(posedge i_clk);
        #1;
        i_reset = 1'b0;
        t_power_up();
        t_ir_codes();
        t_idcode();
        t_bypass();
        t_ring();
        test_done();
    end
endmodule : tb
`default_nettype wire
